// [rtl/ate_pkg.sv]
// Package of constants and types for the address table access engine
package ate_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL0_OFF    = 8'h00;
   localparam logic [7:0] CTRL1_OFF    = 8'h04;
   localparam logic [7:0] CTRL2_OFF    = 8'h08;
   localparam logic [7:0] STAT0_OFF    = 8'h0C;
   localparam logic [7:0] STAT1_OFF    = 8'h10;
   localparam logic [7:0] STAT2_OFF    = 8'h14;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h18;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h1C;
   // Control 1 / status 1 field positions, status 2 busy bit
   localparam int MACHI_LSB = 0;
   localparam int FGRP_LSB  = 16;
   localparam int PORT_LSB  = 19;
   localparam int CFLD_LSB  = 24;
   localparam int STATE_LSB = 26;
   localparam int OCCUPY_BIT = 28;
   localparam int BAD_BIT   = 29;
   localparam int BUSY_BIT  = 3;
   // Command codes
   localparam logic [2:0] CMD_CREATE = 3'h0;
   localparam logic [2:0] CMD_SRCH_PORT = 3'h2;
   localparam logic [2:0] CMD_INIT   = 3'h3;
   // Result codes
   localparam logic [2:0] RES_OK       = 3'h0;
   localparam logic [2:0] RES_ALL_USED = 3'h1;
   localparam logic [2:0] RES_NOT_FOUND = 3'h2;
   localparam logic [2:0] RES_TRY_NEXT = 3'h3;
   localparam logic [2:0] RES_CMD_ERR  = 3'h5;
   // Ways per hash location, interrupt bits
   localparam int WAYS = 4;
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FULL = 1;
   localparam int IRQ_ERR  = 2;
   // Reset values, bus response codes
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [2:0] RES_RST  = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One address table entry
   typedef struct packed {
      logic        occupy;
      logic        bad;
      logic [1:0]  state;   // [0] static, [1] multicast
      logic [1:0]  cfield;
      logic [4:0]  port;
      logic [2:0]  fgroup;
      logic [47:0] mac;
   } ate_entry_s;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_CREATE = 4'b0010,
      ST_SEARCH = 4'b0100,
      ST_SHORT  = 4'b1000
   } ate_state_e;
endpackage

// [rtl/ate_table.sv]
// Entry storage for the hashed address table
`timescale 1ns/1ps
`default_nettype none
module ate_table #(
   parameter int IDX_W = 6
) (
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Write port
   input  wire logic                 we,
   input  wire logic [IDX_W-1:0]     waddr,
   input  wire ate_pkg::ate_entry_s  wdata,
   // Read ports
   input  wire logic [IDX_W-3:0]     loc,
   output ate_pkg::ate_entry_s       ways [ate_pkg::WAYS],
   input  wire logic [IDX_W-1:0]     raddr,
   output ate_pkg::ate_entry_s       rdata
);
   ate_pkg::ate_entry_s mem [2**IDX_W];

   // Reset empties every slot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 2**IDX_W; i++) begin
            mem[i] <= '0;
         end
      end else if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Combinational reads, four ways share one location
   always_comb begin
      for (int w = 0; w < ate_pkg::WAYS; w++) begin
         ways[w] = mem[{loc, 2'(w)}];
      end
      rdata = mem[raddr];
   end
endmodule
`default_nettype wire

// [rtl/ate_irq.sv]
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module ate_irq (
   // Clock and reset
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   // Events and software access
   input  wire logic [ate_pkg::IRQ_W-1:0] event_in,
   input  wire logic                     rd_clr,
   input  wire logic                     mask_we,
   input  wire logic [ate_pkg::IRQ_W-1:0] mask_in,
   // State and interrupt
   output logic [ate_pkg::IRQ_W-1:0]     status,
   output logic [ate_pkg::IRQ_W-1:0]     mask,
   output logic                          irq
);
   // Read clears, but an event in that cycle still lands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
      end else begin
         status <= (rd_clr ? '0 : status) | event_in;
      end
   end

   // Mask, one enables the bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask <= '0;
      end else if (mask_we) begin
         mask <= mask_in;
      end
   end

   // Level output from a flop, one cycle behind status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end
endmodule
`default_nettype wire

// [rtl/ate_engine.sv]
// Address table access engine with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module ate_engine #(
   parameter int LOC_W = 4
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // Write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // Write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // Read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // Read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Interrupt
   output logic             irq
);
   localparam int IDX_W = LOC_W + 2;
   localparam int NENT  = 2**IDX_W;

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   // Fold the MAC into a hash location
   function automatic logic [LOC_W-1:0] hash(input logic [47:0] mac);
      logic [LOC_W-1:0] h;
      h = '0;
      for (int i = 0; i < 48; i++) begin
         h[i % LOC_W] = h[i % LOC_W] ^ mac[i];
      end
      return h;
   endfunction

   // Map known offsets
   function automatic logic mapped(input logic [7:0] a);
      return a inside {ate_pkg::CTRL0_OFF, ate_pkg::CTRL1_OFF,
                       ate_pkg::CTRL2_OFF, ate_pkg::STAT0_OFF,
                       ate_pkg::STAT1_OFF, ate_pkg::STAT2_OFF,
                       ate_pkg::IRQ_STAT_OFF, ate_pkg::IRQ_MASK_OFF};
   endfunction

   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic [31:0] ctrl0_reg, ctrl1_reg, ctrl2_reg;
   logic        busy_reg;
   logic [2:0]  result_reg;
   ate_pkg::ate_entry_s found_reg, cmd_reg, new_entry;
   ate_pkg::ate_state_e state_reg;
   logic [IDX_W:0] ptr_reg;
   logic [ate_pkg::IRQ_W-1:0] event_reg, irq_status, irq_mask;
   ate_pkg::ate_entry_s ways [ate_pkg::WAYS];
   ate_pkg::ate_entry_s ptr_entry;
   logic        do_wr, launch, tab_we, ptr_hit, ptr_end, rd_clr;
   logic [1:0]  pick;
   logic        pick_ok;
   logic [LOC_W-1:0] cmd_loc;
   logic [31:0] rd_mux;

   assign do_wr  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign launch = do_wr && awaddr_reg == ate_pkg::CTRL2_OFF
                   && !busy_reg;
   assign rd_clr = s_axi_arvalid && s_axi_arready
                   && s_axi_araddr == ate_pkg::IRQ_STAT_OFF;

   // Write address and data taken independently, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ate_pkg::RESP_OKAY;
         awaddr_reg    <= '0;
         wdata_reg     <= ate_pkg::REG_RST;
         wstrb_reg     <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_reg    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_reg) ? ate_pkg::RESP_OKAY
                                               : ate_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Control registers; control 2 only while the engine is free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0_reg <= ate_pkg::REG_RST;
         ctrl1_reg <= ate_pkg::REG_RST;
         ctrl2_reg <= ate_pkg::REG_RST;
      end else if (do_wr) begin
         if (awaddr_reg == ate_pkg::CTRL0_OFF)
            ctrl0_reg <= merge(ctrl0_reg, wdata_reg, wstrb_reg);
         if (awaddr_reg == ate_pkg::CTRL1_OFF)
            ctrl1_reg <= merge(ctrl1_reg, wdata_reg, wstrb_reg);
         if (launch)
            ctrl2_reg <= merge(ctrl2_reg, wdata_reg, wstrb_reg);
      end
   end

   // Entry described by controls 0 and 1, snapshot at launch
   always_comb begin
      new_entry        = '0;
      new_entry.mac    = {ctrl1_reg[ate_pkg::MACHI_LSB +: 16],
                          ctrl0_reg};
      new_entry.fgroup = ctrl1_reg[ate_pkg::FGRP_LSB +: 3];
      new_entry.port   = ctrl1_reg[ate_pkg::PORT_LSB +: 5];
      new_entry.cfield = ctrl1_reg[ate_pkg::CFLD_LSB +: 2];
      new_entry.state  = ctrl1_reg[ate_pkg::STATE_LSB +: 2];
      new_entry.occupy = 1'b1;
   end

   assign cmd_loc = hash(cmd_reg.mac);

   // Way choice: same MAC, then empty, then non-static slot; bad slots are skipped for empty and non-static
   always_comb begin
      pick    = 2'd0;
      pick_ok = 1'b0;
      for (int w = ate_pkg::WAYS - 1; w >= 0; w--) begin
         if (!ways[w].bad && !ways[w].state[0]) begin
            pick = 2'(w);
            pick_ok = 1'b1;
         end
      end
      for (int w = ate_pkg::WAYS - 1; w >= 0; w--) begin
         if (!ways[w].bad && !ways[w].occupy) begin
            pick = 2'(w);
            pick_ok = 1'b1;
         end
      end
      for (int w = ate_pkg::WAYS - 1; w >= 0; w--) begin
         if (ways[w].occupy && ways[w].mac == cmd_reg.mac) begin
            pick = 2'(w);
            pick_ok = 1'b1;
         end
      end
   end

   // Search compare at the pointer
   assign ptr_end = ptr_reg == (IDX_W+1)'(NENT);
   assign ptr_hit = !ptr_end && ptr_entry.occupy && !ptr_entry.bad
                    && ptr_entry.port == cmd_reg.port;
   assign tab_we  = state_reg == ate_pkg::ST_CREATE && pick_ok;

   ate_table #(.IDX_W(IDX_W)) u_table (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (tab_we),
      .waddr   ({cmd_loc, pick}),
      .wdata   (cmd_reg),
      .loc     (cmd_loc),
      .ways    (ways),
      .raddr   (ptr_reg[IDX_W-1:0]),
      .rdata   (ptr_entry)
   );

   // Command sequencer; busy clears on the same edge that the result is written
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg  <= ate_pkg::ST_IDLE;
         busy_reg   <= 1'b0;
         result_reg <= ate_pkg::RES_RST;
         cmd_reg    <= '0;
         found_reg  <= '0;
         ptr_reg    <= '0;
         event_reg  <= '0;
      end else begin
         event_reg <= '0;
         unique case (state_reg)
            ate_pkg::ST_IDLE: begin
               if (launch) begin
                  busy_reg <= 1'b1;
                  cmd_reg  <= new_entry;
                  if (wdata_reg[2:0] == ate_pkg::CMD_CREATE)
                     state_reg <= ate_pkg::ST_CREATE;
                  else if (wdata_reg[2:0] == ate_pkg::CMD_SRCH_PORT)
                     state_reg <= ate_pkg::ST_SEARCH;
                  else
                     state_reg <= ate_pkg::ST_SHORT;
               end
            end
            ate_pkg::ST_CREATE: begin
               busy_reg   <= 1'b0;
               state_reg  <= ate_pkg::ST_IDLE;
               event_reg[ate_pkg::IRQ_DONE] <= 1'b1;
               if (pick_ok) begin
                  result_reg <= ate_pkg::RES_OK;
               end else begin
                  result_reg <= ate_pkg::RES_ALL_USED;
                  event_reg[ate_pkg::IRQ_FULL] <= 1'b1;
               end
            end
            ate_pkg::ST_SEARCH: begin
               if (ptr_hit) begin
                  found_reg  <= ptr_entry;
                  ptr_reg    <= ptr_reg + 1'b1;
                  result_reg <= ate_pkg::RES_OK;
                  busy_reg   <= 1'b0;
                  state_reg  <= ate_pkg::ST_IDLE;
                  event_reg[ate_pkg::IRQ_DONE] <= 1'b1;
               end else if (ptr_end) begin
                  result_reg <= ate_pkg::RES_NOT_FOUND;
                  busy_reg   <= 1'b0;
                  state_reg  <= ate_pkg::ST_IDLE;
                  event_reg[ate_pkg::IRQ_DONE] <= 1'b1;
               end else begin
                  ptr_reg <= ptr_reg + 1'b1;
               end
            end
            ate_pkg::ST_SHORT: begin
               busy_reg  <= 1'b0;
               state_reg <= ate_pkg::ST_IDLE;
               event_reg[ate_pkg::IRQ_DONE] <= 1'b1;
               if (ctrl2_reg[2:0] == ate_pkg::CMD_INIT) begin
                  ptr_reg    <= '0;
                  result_reg <= ate_pkg::RES_OK;
               end else begin
                  result_reg <= ate_pkg::RES_CMD_ERR;
                  event_reg[ate_pkg::IRQ_ERR] <= 1'b1;
               end
            end
            default: state_reg <= ate_pkg::ST_IDLE;
         endcase
      end
   end

   ate_irq u_irq (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .event_in (event_reg),
      .rd_clr   (rd_clr),
      .mask_we  (do_wr && awaddr_reg == ate_pkg::IRQ_MASK_OFF),
      .mask_in  (wdata_reg[ate_pkg::IRQ_W-1:0]),
      .status   (irq_status),
      .mask     (irq_mask),
      .irq      (irq)
   );

   // Read mux; status 1 mirrors the control 1 layout
   always_comb begin
      rd_mux = '0;
      unique case (s_axi_araddr)
         ate_pkg::CTRL0_OFF: rd_mux = ctrl0_reg;
         ate_pkg::CTRL1_OFF: rd_mux = ctrl1_reg;
         ate_pkg::CTRL2_OFF: rd_mux = ctrl2_reg;
         ate_pkg::STAT0_OFF: rd_mux = found_reg.mac[31:0];
         ate_pkg::STAT1_OFF: begin
            rd_mux[ate_pkg::MACHI_LSB +: 16] = found_reg.mac[47:32];
            rd_mux[ate_pkg::FGRP_LSB +: 3]   = found_reg.fgroup;
            rd_mux[ate_pkg::PORT_LSB +: 5]   = found_reg.port;
            rd_mux[ate_pkg::CFLD_LSB +: 2]   = found_reg.cfield;
            rd_mux[ate_pkg::STATE_LSB +: 2]  = found_reg.state;
            rd_mux[ate_pkg::OCCUPY_BIT]      = found_reg.occupy;
            rd_mux[ate_pkg::BAD_BIT]         = found_reg.bad;
         end
         ate_pkg::STAT2_OFF: begin
            rd_mux[ate_pkg::BUSY_BIT] = busy_reg;
            rd_mux[2:0]               = result_reg;
         end
         ate_pkg::IRQ_STAT_OFF: rd_mux[ate_pkg::IRQ_W-1:0] = irq_status;
         ate_pkg::IRQ_MASK_OFF: rd_mux[ate_pkg::IRQ_W-1:0] = irq_mask;
         default: rd_mux = '0;
      endcase
   end

   // Read channel, data captured on the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= ate_pkg::REG_RST;
         s_axi_rresp   <= ate_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= mapped(s_axi_araddr) ? ate_pkg::RESP_OKAY
                                               : ate_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [verification/ate_engine_sva.sv]
// Bus handshake and response assertions for the table access engine
`timescale 1ns/1ps
`default_nettype none
module ate_engine_sva #(
   parameter int LOC_W = 4
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   // Read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   // Interrupt
   input wire logic        irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Handshake helpers; bench offers address and data together
   logic wr_hs;
   logic ar_hs;
   assign wr_hs = s_axi_awvalid && s_axi_awready
                  && s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;

   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
   // Response registers one edge after the write executes
   property p_b_after;
      wr_hs |=> !s_axi_awready ##1 s_axi_bvalid;
   endproperty
   a_b_after: assert property (p_b_after) else $error("no bvalid");
   property p_b_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_b_block: assert property (p_b_block) else $error("write overlap");
   property p_back;
      s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
   endproperty
   a_back: assert property (p_back) else $error("ready not back");
   property p_r_after;
      ar_hs |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_r_after: assert property (p_r_after) else $error("no rvalid");
   property p_rd_err;
      ar_hs && s_axi_araddr > 8'h1C
         |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("bad read resp");
   // Only aligned words are mapped
   property p_rd_ok;
      ar_hs && s_axi_araddr <= 8'h1C && s_axi_araddr[1:0] == 2'h0
         |=> s_axi_rresp == 2'h0;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("read not okay");
   property p_wr_err;
      wr_hs && s_axi_awaddr > 8'h1C |=> ##1 s_axi_bresp == 2'h2;
   endproperty
   a_wr_err: assert property (p_wr_err) else $error("bad write resp");

   // Main scenarios reached
   c_cmd: cover property (wr_hs && s_axi_awaddr == 8'h08);
   c_stat: cover property (ar_hs && s_axi_araddr == 8'h14);
   c_irq: cover property ($rose(irq));
endmodule

bind ate_engine ate_engine_sva #(.LOC_W(LOC_W)) ate_engine_sva_i (
   .aclk(aclk), .aresetn(aresetn), .irq(irq),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp)
);
`default_nettype wire

// [verification/ate_engine_tb_top.sv]
// Self-checking bench for the table access engine
`timescale 1ns/1ps
`default_nettype none
module ate_engine_tb_top;
   typedef struct {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  resp;
   } ate_row_s;
   // Register rows: write, or read with expected data
   ate_row_s    rows [9] = '{
      '{1'b1, 8'h00, 32'h3456_789A, 2'h0},
      '{1'b0, 8'h00, 32'h3456_789A, 2'h0},
      '{1'b1, 8'h04, 32'h5C62_0012, 2'h0},
      '{1'b0, 8'h04, 32'h5C62_0012, 2'h0},
      '{1'b1, 8'h20, 32'h0000_0001, 2'h2},
      '{1'b0, 8'h20, 32'h0000_0000, 2'h2},
      '{1'b0, 8'h14, 32'h0000_0000, 2'h0},
      '{1'b1, 8'h0C, 32'hFFFF_FFFF, 2'h0},
      '{1'b0, 8'h0C, 32'h0000_0000, 2'h0}};
   // Four static entries hashing to location 0, ports 4, 3, 4, 4
   logic [31:0] macs [4] = '{32'h0000_000F, 32'h0000_0033,
                             32'h0000_003C, 32'h0000_00F0};
   logic [31:0] c1s  [4] = '{32'h0420_0000, 32'h0418_0000,
                             32'h0420_0000, 32'h0420_0000};
   logic [31:0] hits [3] = '{32'h0000_000F, 32'h0000_003C, 32'h0000_00F0};
   logic [31:0] errs [5] = '{32'h1, 32'h4, 32'h5, 32'h6, 32'h7};
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        bry = 1'b0;
   logic        arv = 1'b0;
   logic        rry = 1'b0;
   logic [7:0]  awa = 8'h00;
   logic [7:0]  ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic        awr, wrdy, bv, arr, rv, irq;
   logic [1:0]  br, rr, r;
   logic [31:0] rd, v;
   int          n_fail = 0;
   int          compares = 0;
   int          cyc = 0;

   always #12.5 aclk = ~aclk;

   ate_engine #(.LOC_W(2)) ate_engine_i (
      .aclk(aclk), .aresetn(aresetn), .irq(irq),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .s_axi_rdata(rd), .s_axi_rresp(rr)
   );

   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Each channel released at its own handshake edge
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] q);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!(bv && bry));
      q = br;
      bry <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] q);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 1'b0;
      end while (!(rv && rry));
      d = rd;
      q = rr;
      rry <= 1'b0;
   endtask

   // Launch a command, then poll busy until the engine is free
   task automatic cmd(input logic [31:0] c, output logic [31:0] s);
      wr_reg(8'h08, c, r);
      do rd_reg(8'h14, s, r); while (s[3] === 1'b1);
      s = s & 32'h0000_000F;
   endtask

   task automatic cr(input logic [31:0] lo, input logic [31:0] c1);
      wr_reg(8'h00, lo, r);
      wr_reg(8'h04, c1, r);
      cmd(32'h0, v);
   endtask

   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         complete_run();
      end
   end

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr_reg(rows[i].a, rows[i].d, r);
         else begin
            rd_reg(rows[i].a, v, r);
            chk("row data", v, rows[i].d);
         end
         chk("row resp", {30'h0, r}, {30'h0, rows[i].resp});
      end
      $display("register rows done");
      // Fill location 0, then a fifth static create must fail
      wr_reg(8'h1C, 32'h0000_0007, r);
      foreach (macs[i]) begin
         cr(macs[i], c1s[i]);
         chk("create result", v, 32'h0);
      end
      cr(32'h0000_00C3, 32'h0420_0000);
      chk("full result", v, 32'h1);
      chk("irq raised", {31'h0, irq}, 32'h1);
      rd_reg(8'h18, v, r);
      chk("irq status", v & 32'h7, 32'h3);
      rd_reg(8'h18, v, r);
      chk("irq cleared", v & 32'h7, 32'h0);
      chk("irq low", {31'h0, irq}, 32'h0);
      $display("create test done");
      // Unsupported codes report an error; interrupt masked off
      wr_reg(8'h1C, 32'h0000_0000, r);
      foreach (errs[i]) begin
         cmd(errs[i], v);
         chk("error result", v, 32'h5);
      end
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd_reg(8'h18, v, r);
      chk("error event", v & 32'h4, 32'h4);
      $display("error test done");
      // Search by port 4 walks slots upward from slot 0, then runs dry
      cmd(32'h3, v);
      chk("init result", v, 32'h0);
      wr_reg(8'h04, 32'h0020_0000, r);
      foreach (hits[i]) begin
         cmd(32'h2, v);
         chk("search result", v, 32'h0);
         rd_reg(8'h0C, v, r);
         chk("found mac", v, hits[i]);
         rd_reg(8'h10, v, r);
         chk("found port", v & 32'h00F8_0000, 32'h0020_0000);
      end
      cmd(32'h2, v);
      chk("search end", v, 32'h2);
      $display("search test done");
      // Long empty search: busy shows, a second command is refused
      cmd(32'h3, v);
      wr_reg(8'h04, 32'h0048_0000, r);
      wr_reg(8'h08, 32'h0000_0002, r);
      rd_reg(8'h14, v, r);
      chk("busy seen", v & 32'h8, 32'h8);
      wr_reg(8'h08, 32'h0000_0003, r);
      do rd_reg(8'h14, v, r); while (v[3] === 1'b1);
      chk("busy refused", v & 32'hF, 32'h2);
      $display("busy test done");
      // Slow master: bvalid and bresp must stand until bready
      @(posedge aclk);
      awa <= 8'h20;
      wd <= 32'h0000_0000;
      awv <= 1'b1;
      wv <= 1'b1;
      @(posedge aclk);
      awv <= 1'b0;
      wv <= 1'b0;
      repeat (3) @(posedge aclk);
      bry <= 1'b1;
      @(posedge aclk);
      bry <= 1'b0;
      chk("slow write", {30'h0, br}, 32'h0000_0002);
      // Slow master: rvalid and rdata must stand until rready
      @(posedge aclk);
      ara <= 8'h04;
      arv <= 1'b1;
      @(posedge aclk);
      arv <= 1'b0;
      repeat (3) @(posedge aclk);
      rry <= 1'b1;
      @(posedge aclk);
      rry <= 1'b0;
      chk("slow read", rd, 32'h0048_0000);
      $display("slow master test done");
      // Reset in mid-run restores idle state
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(8'h14, v, r);
      chk("reset status", v, 32'h0);
      rd_reg(8'h00, v, r);
      chk("reset ctrl0", v, 32'h0);
      chk("reset irq", {31'h0, irq}, 32'h0);
      $display("reset test done");
      complete_run();
   end
endmodule
`default_nettype wire
